/* ccerr_pkg.sv */
// Constants shared by the control channel error register block.
// Assumes an 8-bit register space reached through the local I2C slave.
package ccerr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CCERR_CHANNEL_ERROR_CONTROL_ADDR = 8'h46;
    localparam logic [7:0] CCERR_CHANNEL_ERROR_STATUS_ADDR  = 8'h47;
    localparam logic [7:0] CCERR_RECEIVE_PORT_SELECT_ADDR   = 8'h4C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CCERR_NUM_PORTS          = 4;
    localparam int CCERR_SELF_ACK_BIT       = 7;
    localparam int CCERR_DATA_CHECK_BIT     = 6;
    localparam int CCERR_ENH_CHECK_BIT      = 5;
    localparam int CCERR_INJECT_MODE_HI     = 4;
    localparam int CCERR_INJECT_MODE_LO     = 3;
    localparam int CCERR_BYTE_INDEX_HI      = 2;
    localparam int CCERR_BYTE_INDEX_LO      = 0;
    localparam int CCERR_SEQ_ERR_BIT        = 5;
    localparam int CCERR_MASTER_ERR_BIT     = 4;
    localparam int CCERR_READ_SEL_HI        = 5;
    localparam int CCERR_READ_SEL_LO        = 4;
    localparam int CCERR_WRITE_EN_HI        = 3;
    localparam int CCERR_WRITE_EN_LO        = 0;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] CCERR_CONTROL_RESET     = 8'h20;
    localparam logic [7:0] CCERR_PORT_SELECT_RESET = 8'h01;
    localparam logic [7:0] CCERR_PORT_SELECT_MASK  = 8'h3F;
    localparam logic [3:0] CCERR_FIRST_BYTES       = 4'h8;

    // ------------------------------------------------------------------
    // Fault injection modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CCERR_INJ_NONE       = 2'b00,
        CCERR_INJ_CRC_SEL    = 2'b01,
        CCERR_INJ_CRC_NEXT   = 2'b10,
        CCERR_INJ_DATA_SEL   = 2'b11
    } ccerr_inject_mode_type;

    // Per-port injection sequencer
    typedef enum logic [1:0] {
        CCERR_ST_IDLE        = 2'b00,
        CCERR_ST_WAIT_BYTE   = 2'b01,
        CCERR_ST_WAIT_NORMAL = 2'b10
    } ccerr_state_type;

endpackage

/* ccerr_regs.sv */
// Control channel error checking and fault injection registers, four ports.
// Assumes a register access port from the local I2C slave on sys_clk, and
// per-port channel events from link logic on the same clock.
module ccerr_regs
    import ccerr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register access from the I2C slave
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    // Per-port channel events
    input  wire logic [3:0] fwd_frame_start,
    input  wire logic [3:0] fwd_byte_sent,
    input  wire logic [3:0] fwd_normal_frame,
    input  wire logic [3:0] fwd_seq_err,
    input  wire logic [3:0] fwd_crc_err,
    input  wire logic [3:0] fwd_lock_err,
    input  wire logic [3:0] port_seq_err_copy,
    input  wire logic [3:0] master_waiting,
    input  wire logic [3:0] echo_valid,
    input  wire logic [3:0] echo_match,
    input  wire logic [3:0] remote_ack,
    // Per-port channel controls
    output logic      [3:0] remote_read_self_ack,
    output logic      [3:0] local_ack_valid,
    output logic      [3:0] local_ack,
    output logic      [3:0] terminate_txn,
    output logic      [3:0] inject_crc_err,
    output logic      [3:0] inject_data_err
);

    // ------------------------------------------------------------------
    // Shared decode
    // ------------------------------------------------------------------
    logic [7:0] port_sel_reg;           // Port select register
    logic [7:0] port_sel_next;          // Its next value
    logic [7:0] ctl_q [CCERR_NUM_PORTS]; // Control register of each port
    logic [7:0] sts_q [CCERR_NUM_PORTS]; // Status read value of each port
    logic [1:0] read_port;              // Port chosen for reads
    logic [3:0] write_ports;            // Ports that take writes
    logic       ctl_write;              // Write strobe to control register
    logic       sts_read;               // Read strobe of status register
    logic [7:0] rdata_next;             // Next read data

    // Reads follow one port, writes may fan out to several at once
    assign read_port   = port_sel_reg[CCERR_READ_SEL_HI:CCERR_READ_SEL_LO];
    assign write_ports = port_sel_reg[CCERR_WRITE_EN_HI:CCERR_WRITE_EN_LO];
    // Strobes of the two per-port registers
    assign ctl_write   = reg_wr &&
                         (reg_addr == CCERR_CHANNEL_ERROR_CONTROL_ADDR);
    // A status read is what clears the sticky flags of the read port
    assign sts_read    = reg_rd &&
                         (reg_addr == CCERR_CHANNEL_ERROR_STATUS_ADDR);

    // ------------------------------------------------------------------
    // Port select register and read mux
    // ------------------------------------------------------------------

    // Next value of port select and read data
    always_comb begin
        port_sel_next = port_sel_reg;
        rdata_next    = 8'h00;
        // Upper bits unused, kept at zero
        if (reg_wr && (reg_addr == CCERR_RECEIVE_PORT_SELECT_ADDR)) begin
            port_sel_next = reg_wdata & CCERR_PORT_SELECT_MASK;
        end
        case (reg_addr)
            CCERR_RECEIVE_PORT_SELECT_ADDR: begin
                rdata_next = port_sel_reg;
            end
            CCERR_CHANNEL_ERROR_CONTROL_ADDR: begin
                rdata_next = ctl_q[read_port];
            end
            CCERR_CHANNEL_ERROR_STATUS_ADDR: begin
                rdata_next = sts_q[read_port];
            end
            default: begin
                rdata_next = 8'h00; // Unmapped reads return zero
            end
        endcase
    end

    // Register port select and the read answer
    // Read data holds between reads so a slow master may take it late;
    // rvalid marks the one cycle in which a fresh answer stands
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_sel_reg <= CCERR_PORT_SELECT_RESET;
            reg_rdata    <= 8'h00;
            reg_rvalid   <= 1'b0;
        end else begin
            port_sel_reg <= port_sel_next;
            reg_rvalid   <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-port logic
    // ------------------------------------------------------------------
    // Each port keeps its own control copy, flags and injection sequencer;
    // only the bus decode above is shared between them.
    // Reset puts every port back to enhanced checking with no fault armed
    genvar p;
    generate
        for (p = 0; p < CCERR_NUM_PORTS; p++) begin : g_port
            logic [7:0]      ctl_reg;        // Control register
            logic [7:0]      ctl_next;
            logic            seq_reg;        // Sticky sequence error
            logic            seq_next;
            logic            mst_reg;        // Sticky master error
            logic            mst_next;
            ccerr_state_type st_reg;         // Injection sequencer
            ccerr_state_type st_next;
            logic [3:0]      cnt_reg;        // Bytes sent in this transfer
            logic [3:0]      cnt_next;
            logic            crc_next;
            logic            data_next;
            logic            ackv_next;
            logic            ack_next;
            logic            term_next;
            logic            enh;            // Enhanced checking enabled
            logic            any_err;        // Any forward channel error
            logic            clr_rd;         // This port's status is read
            ccerr_inject_mode_type mode;     // Programmed injection mode
            logic [2:0]      byte_sel;       // Programmed byte index

            assign enh      = ctl_reg[CCERR_ENH_CHECK_BIT];
            assign any_err  = fwd_seq_err[p] | fwd_crc_err[p] | fwd_lock_err[p];
            // Only the port whose status is shown loses its flags on a read
            assign clr_rd   = sts_read && (read_port == 2'(p));
            assign mode     = ccerr_inject_mode_type'(
                ctl_reg[CCERR_INJECT_MODE_HI:CCERR_INJECT_MODE_LO]);
            assign byte_sel = ctl_reg[CCERR_BYTE_INDEX_HI:CCERR_BYTE_INDEX_LO];
            assign ctl_q[p] = ctl_reg;

            // Status view; the mirror applies while enhanced checking is off
            // Bits 3:0 are built elsewhere and read zero from this block
            always_comb begin
                sts_q[p] = 8'h00;
                if (enh) begin
                    sts_q[p][CCERR_SEQ_ERR_BIT]    = seq_reg;
                    sts_q[p][CCERR_MASTER_ERR_BIT] = mst_reg;
                end else begin
                    sts_q[p][CCERR_SEQ_ERR_BIT] =
                        port_seq_err_copy[p];
                end
            end

            // Next state of registers, flags and injection
            // Pulse outputs default low so that each fires for one cycle
            always_comb begin
                ctl_next  = ctl_reg;
                seq_next  = seq_reg;
                mst_next  = mst_reg;
                st_next   = st_reg;
                cnt_next  = cnt_reg;
                crc_next  = 1'b0;
                data_next = 1'b0;
                // Multicast write to every enabled port
                if (ctl_write && write_ports[p]) begin
                    ctl_next = reg_wdata;
                end
                // Clear first, then a same-cycle event sets again
                if (clr_rd && enh) begin
                    seq_next = 1'b0;
                    mst_next = 1'b0;
                end
                if (enh && fwd_seq_err[p]) begin
                    seq_next = 1'b1;
                end
                if (enh && any_err && master_waiting[p]) begin
                    mst_next = 1'b1;
                end
                // Count bytes of the transfer, saturating past the window
                // Saturation keeps a long transfer from wrapping onto a match
                if (fwd_frame_start[p]) begin
                    cnt_next = 4'h0;
                end else if (fwd_byte_sent[p] &&
                             (cnt_reg != CCERR_FIRST_BYTES)) begin
                    cnt_next = cnt_reg + 4'h1;
                end
                case (st_reg)
                    CCERR_ST_IDLE: begin
                        st_next = CCERR_ST_IDLE;
                    end
                    CCERR_ST_WAIT_BYTE: begin
                        if (fwd_byte_sent[p] && !fwd_frame_start[p] &&
                            (cnt_reg == {1'b0, byte_sel})) begin
                            case (mode)
                                CCERR_INJ_CRC_SEL: begin
                                    crc_next = 1'b1;
                                    st_next  = CCERR_ST_IDLE;
                                end
                                CCERR_INJ_CRC_NEXT: begin
                                    st_next = CCERR_ST_WAIT_NORMAL;
                                end
                                CCERR_INJ_DATA_SEL: begin
                                    data_next = 1'b1;
                                    st_next   = CCERR_ST_IDLE;
                                end
                                default: begin
                                    st_next = CCERR_ST_IDLE;
                                end
                            endcase
                        end
                    end
                    CCERR_ST_WAIT_NORMAL: begin
                        if (fwd_normal_frame[p]) begin
                            crc_next = 1'b1;
                            st_next  = CCERR_ST_IDLE;
                        end
                    end
                    default: begin
                        st_next = CCERR_ST_IDLE;
                    end
                endcase
                // A fresh nonzero write re-arms exactly one injection
                // A write wins over the sequencer, so a rewrite restarts it
                if (ctl_write && write_ports[p]) begin
                    if (reg_wdata[CCERR_INJECT_MODE_HI:CCERR_INJECT_MODE_LO]
                        != CCERR_INJ_NONE) begin
                        st_next = CCERR_ST_WAIT_BYTE;
                    end else begin
                        st_next = CCERR_ST_IDLE;
                    end
                end
            end

            // ----------------------------------------------------------
            // Acknowledge path
            // ----------------------------------------------------------

            // Acknowledge handling on the local bus; the answer is held back
            // one cycle so the Nack decision never races the echo compare
            always_comb begin
                ackv_next = echo_valid[p];
                ack_next  = remote_ack[p];
                // Mismatched echo turns the Ack into a Nack while data checking is enabled
                if (ctl_reg[CCERR_DATA_CHECK_BIT] && !echo_match[p]) begin
                    ack_next = 1'b0;
                end
                // Terminate on any channel error while enabled
                term_next = enh && any_err;
            end

            // ----------------------------------------------------------
            // Per-port registers
            // ----------------------------------------------------------

            // Register every per-port state element
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    ctl_reg                 <= CCERR_CONTROL_RESET;
                    seq_reg                 <= 1'b0;
                    mst_reg                 <= 1'b0;
                    st_reg                  <= CCERR_ST_IDLE;
                    cnt_reg                 <= 4'h0;
                    inject_crc_err[p]       <= 1'b0;
                    inject_data_err[p]      <= 1'b0;
                    local_ack_valid[p]      <= 1'b0;
                    local_ack[p]            <= 1'b0;
                    terminate_txn[p]        <= 1'b0;
                    remote_read_self_ack[p] <= 1'b0;
                end else begin
                    ctl_reg                 <= ctl_next;
                    seq_reg                 <= seq_next;
                    mst_reg                 <= mst_next;
                    st_reg                  <= st_next;
                    cnt_reg                 <= cnt_next;
                    inject_crc_err[p]       <= crc_next;
                    inject_data_err[p]      <= data_next;
                    local_ack_valid[p]      <= ackv_next;
                    local_ack[p]            <= ack_next;
                    terminate_txn[p]        <= term_next;
                    // Self-ack is only safe with an enhanced partner
                    remote_read_self_ack[p] <=
                        ctl_next[CCERR_SELF_ACK_BIT];
                end
            end
        end
    endgenerate

endmodule // ccerr_regs

/* ccerr_regs_properties.sv */
// Checker for the control channel error registers, bound to ccerr_regs.
// Assumes one clock, sys_clk, and a synchronous active high rst.
module ccerr_regs_properties (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] fwd_byte_sent,
    input wire logic [3:0] fwd_normal_frame,
    input wire logic [3:0] fwd_seq_err,
    input wire logic [3:0] fwd_crc_err,
    input wire logic [3:0] fwd_lock_err,
    input wire logic [3:0] echo_valid,
    input wire logic [3:0] echo_match,
    input wire logic [3:0] remote_ack,
    input wire logic [3:0] remote_read_self_ack,
    input wire logic [3:0] local_ack,
    input wire logic [3:0] terminate_txn,
    input wire logic [3:0] inject_crc_err,
    input wire logic [3:0] inject_data_err
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Timing relations at the ports
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0] inj;   // Either kind of injected fault, per port
    assign inj = inject_crc_err | inject_data_err;
    property p_read_answer; reg_rd |=> reg_rvalid; endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer missing");
    // Bits 7:6 are reserved and 3:0 are not built here: all read zero
    property p_status_zero;
        reg_rvalid && $past(reg_addr) == 8'h47
            |-> (reg_rdata & 8'hcf) == 8'h00;
    endproperty
    a_status_zero: assert property (p_status_zero)
        else $error("status reserved bits not zero");
    property p_self_ack_hold;
        !$past(reg_wr) |-> $stable(remote_read_self_ack);
    endproperty
    a_self_ack_hold: assert property (p_self_ack_hold)
        else $error("self ack moved without a write");
    // A matching echo must pass the remote answer through untouched
    property p_ack_pass;
        (echo_valid & echo_match) != 4'h0 |=> ((local_ack ^
            $past(remote_ack)) & $past(echo_valid & echo_match)) == 4'h0;
    endproperty
    a_ack_pass: assert property (p_ack_pass)
        else $error("ack altered on matching echo");
    property p_inj_single; (inj & $past(inj)) == 4'h0; endproperty
    a_inj_single: assert property (p_inj_single)
        else $error("injection lasted two cycles");
    property p_data_cause;
        (inject_data_err & ~$past(fwd_byte_sent)) == 4'h0;
    endproperty
    a_data_cause: assert property (p_data_cause)
        else $error("data fault not after a byte");
    property p_crc_cause;
        (inject_crc_err & ~$past(fwd_byte_sent | fwd_normal_frame)) == 4'h0;
    endproperty
    a_crc_cause: assert property (p_crc_cause)
        else $error("crc fault not after a byte or frame");
    property p_term_cause; (terminate_txn & ~$past(fwd_seq_err |
        fwd_crc_err | fwd_lock_err)) == 4'h0; endproperty
    a_term_cause: assert property (p_term_cause)
        else $error("terminate without an error");
    c_crc: cover property (inject_crc_err != 4'h0);
    c_data: cover property (inject_data_err != 4'h0);
    c_term: cover property (terminate_txn != 4'h0);
endmodule // ccerr_regs_properties

/* ccerr_serializer_model.sv */
// Remote serializer model: forward channel transfers of eight bytes.
// Assumes go pulses from the bench; outputs change after sys_clk rises.
module ccerr_serializer_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] go,
    output logic      [3:0] fwd_frame_start,
    output logic      [3:0] fwd_byte_sent,
    output logic      [3:0] fwd_normal_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mask_reg, mask_next;   // Ports in this transfer
    logic [4:0] step_reg, step_next;   // 0 idle, 1 start, 19 normal frame
    // Start, eight bytes an idle cycle apart, then one normal frame
    always_comb begin
        mask_next = (step_reg == 5'h00) ? go : mask_reg;
        step_next = (step_reg == 5'h13) ? 5'h00 : step_reg + 5'h01;
        if (step_reg == 5'h00 && go == 4'h0) begin
            step_next = 5'h00;
        end
    end
    always_ff @(posedge sys_clk) begin
        mask_reg <= rst ? 4'h0 : mask_next;
        step_reg <= rst ? 5'h00 : step_next;
    end
    assign fwd_frame_start  = (step_reg == 5'h01) ? mask_reg : 4'h0;
    assign fwd_byte_sent    = (step_reg[0] && step_reg >= 5'h03 &&
                               step_reg <= 5'h11) ? mask_reg : 4'h0;
    assign fwd_normal_frame = (step_reg == 5'h13) ? mask_reg : 4'h0;
endmodule // ccerr_serializer_model

/* testbench.sv */
// Self-checking bench for the control channel error registers.
// Assumes the design, its checker and the serializer model are compiled.
module testbench
    import ccerr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
    logic       reg_rvalid;
    logic [3:0] go = 4'h0, fwd_seq_err = 4'h0, fwd_crc_err = 4'h0;
    logic [3:0] fwd_lock_err = 4'h0, port_seq_err_copy = 4'h0;
    logic [3:0] master_waiting = 4'h0, echo_valid = 4'h0;
    logic [3:0] echo_match = 4'h0, remote_ack = 4'h0;
    logic [3:0] fwd_frame_start, fwd_byte_sent, fwd_normal_frame;
    logic [3:0] remote_read_self_ack, local_ack_valid, local_ack;
    logic [3:0] terminate_txn, inject_crc_err, inject_data_err;
    logic [7:0] ctl [4];   // Expected control register of each port
    logic [7:0] sel;       // Expected port select
    integer     seed = 40679;
    int error_cnt = 0, comparisons = 0, np = 0, bcnt = 0, pcnt, pkind;
    int m, n, i;
    always #4 sys_clk = ~sys_clk;
    ccerr_regs ccerr_regs_i (.*);
    ccerr_serializer_model ccerr_serializer_model_i (.*);
    // ------------------------------------------------------------
    // Monitor, tasks and expectations
    // ------------------------------------------------------------
    // Byte count of port n when any injection pulse shows up
    always @(posedge sys_clk) begin
        if (fwd_frame_start[n]) bcnt <= 0;
        else if (fwd_byte_sent[n]) bcnt <= bcnt + 1;
        if ((inject_crc_err | inject_data_err) != 4'h0) begin
            np <= np + 1;
            pcnt <= bcnt;
            pkind <= inject_data_err[n];
        end
    end
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask
    // Nack replaces the remote answer only on a checked mismatch
    function automatic logic exp_ack(input logic en, mt, ak);
        return ak & ~(en & ~mt);
    endfunction
    // Write strobe of one cycle; the bench model follows the write
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        if (a == 8'h4c) sel = d & 8'h3f;
        if (a == 8'h46) for (int k = 0; k < 4; k++) if (sel[k]) ctl[k] = d;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        int w;
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        for (w = 0; w < 4 && reg_rvalid !== 1'b1; w++) @(posedge sys_clk);
        if (w == 4) begin
            error_cnt++;
            print_verdict();
        end else chk("reg_rdata", e, reg_rdata);
    endtask
    // One error pulse of kind k on port 0
    task automatic err_pulse(input int k, input logic e);
        @(posedge sys_clk);
        {fwd_lock_err[0], fwd_crc_err[0], fwd_seq_err[0]} <= 3'h1 << k;
        @(posedge sys_clk);
        {fwd_lock_err[0], fwd_crc_err[0], fwd_seq_err[0]} <= 3'h0;
        #1;
        chk1("terminate_txn", e, terminate_txn[0]);
    endtask
    task automatic frame();
        @(posedge sys_clk);
        go <= 4'h1 << n;
        @(posedge sys_clk);
        go <= 4'h0;
        repeat (24) @(posedge sys_clk);
    endtask
    initial begin
        for (i = 0; i < 4; i++) ctl[i] = CCERR_CONTROL_RESET;
        sel = CCERR_PORT_SELECT_RESET;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(8'h46, 8'h20);
        rdc(8'h4c, 8'h01);
        rdc(8'h48, 8'h00);
        for (n = 0; n < 4; n++) begin
            wr(8'h4c, {2'h0, 2'(n), 4'(1 << n)});
            v = 8'($random(seed));
            wr(8'h46, v & 8'he7);
        end
        for (n = 0; n < 4; n++) begin
            wr(8'h4c, {2'h0, 2'(n), 4'h0});
            wr(8'h46, 8'h5a);   // No write enable, so lands nowhere
            rdc(8'h46, ctl[n]);
            chk1("self_ack", ctl[n][7], remote_read_self_ack[n]);
        end
        wr(8'h4c, 8'hcf);
        rdc(8'h4c, 8'h0f);
        wr(8'h46, 8'h45);
        for (n = 0; n < 4; n++) begin
            wr(8'h4c, {2'h0, 2'(n), 4'hf});
            rdc(8'h46, 8'h45);
        end
        for (m = 1; m < 4; m++) begin
            n = m;
            i = $random(seed) & 7;
            wr(8'h4c, {2'h0, 2'(n), 4'(1 << n)});
            wr(8'h46, {3'h1, 2'(m), 3'(i)});
            np = 0;
            frame();
            frame();
            chk("pulses", 8'h01, 8'(np));
            chk("byte", (m == 2) ? 8'h08 : 8'(i + 1), 8'(pcnt));
            chk1("kind", m == 3, pkind[0]);
        end
        n = 0;
        wr(8'h4c, 8'h01);
        wr(8'h46, 8'h20);
        master_waiting <= 4'h1;
        for (m = 0; m < 3; m++) begin
            err_pulse(m, 1'b1);
            rdc(8'h47, (m == 0) ? 8'h30 : 8'h10);
            rdc(8'h47, 8'h00);
        end
        @(posedge sys_clk) master_waiting <= 4'h0;
        err_pulse(0, 1'b1);
        rdc(8'h47, 8'h20);
        wr(8'h47, 8'hff);
        rdc(8'h47, 8'h00);
        wr(8'h46, 8'h00);
        master_waiting <= 4'h1;
        err_pulse(0, 1'b0);
        @(posedge sys_clk) port_seq_err_copy <= 4'h1;
        rdc(8'h47, 8'h20);
        rdc(8'h47, 8'h20);
        @(posedge sys_clk) port_seq_err_copy <= 4'h0;
        rdc(8'h47, 8'h00);
        for (i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            wr(8'h46, {v[7:6], 6'h20});
            @(posedge sys_clk);
            echo_valid <= 4'h1;
            echo_match <= {3'h0, v[1]};
            remote_ack <= {3'h0, v[0]};
            @(posedge sys_clk);
            echo_valid <= 4'h0;
            #1;
            chk1("ack_valid", 1'b1, local_ack_valid[0]);
            chk1("local_ack", exp_ack(v[6], v[1], v[0]),
                 local_ack[0]);
            chk1("self_ack", v[7], remote_read_self_ack[0]);
        end
        print_verdict();
    end
endmodule // testbench
bind ccerr_regs ccerr_regs_properties ccerr_regs_properties_i (.*);
